/* shared/fmt_cfg.svh */
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: AXI4-Lite slave with 32-bit data, one register per aligned word
// Notes: Definitions only
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH
`define REG_CTRL 8'h00
`define REG_REQSIZE 8'h04
`define REG_EFFSIZE 8'h08
`define REG_STATUS 8'h0C
`define REG_MEMSIZE 8'h10
`define REG_VME_DATA 8'h14
`define REG_CMD 8'h18
`define CTRL_TYPE 0
`define CTRL_WIDE 1
`define CTRL_CONT 2
`define CTRL_APPEND 3
`define CTRL_LBUS 4
`define STAT_SETUP_ERR 6
`define STAT_RUN 0
`define STAT_AVAIL 1
`define STAT_FULL 2
`define CMD_ARM 0
`define CMD_TRIG 1
`define CMD_ABORT 2
`define CTRL_RESET 32'h0000_0002
`define REQSIZE_RESET 32'h0000_0400
`define STD_MEM_MB 16'h0008
`define STREAM_PACE 2
`endif

/* shared/fmt_pkg.sv */
// Purpose: Types shared by the output formatter
// Assumes: Constants live in fmt_cfg.svh
// Notes: Packed structs carry grouped signals
package fmt_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARMED = 3'b001,
        ST_RUN = 3'b011,
        ST_STAT = 3'b010,
        ST_DONE = 3'b110
    } fmt_state_t;
    typedef struct packed {
        logic lbus;
        logic append;
        logic cont;
        logic wide;
        logic cplx;
    } fmt_ctrl_t;
    typedef struct packed {
        logic [31:0] real_component_word;
        logic [31:0] imag_component_word;
        logic overload;
        logic adc_error;
    } sample_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic valid;
    } lbus_byte_t;
endpackage : fmt_pkg

/* core/sample_block_output_formatter.sv */
// Purpose: Formats filtered samples into output blocks for two ports
// Assumes: One DSP clock; samples arrive with valid/ready handshake
// Notes: AXI4-Lite register access; VME words read from a data register
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "fmt_cfg.svh"

// Functional notes
// - Real type sends only the real component of each sample.
// - Complex type sends real component then imaginary component.
// - Resolution selects 16-bit or 32-bit components.
// - Block mode stops after each block; re-arm and trigger needed.
// - Continuous mode runs gapless blocks; reader must drain fast enough.
// - Requested size accepted from 1 to memory bytes over two.
// - Effective size is the next power of two at or above request.
// - Out of range request is clamped and setup error bit 6 set.
// - Request is kept; other setting changes move size toward it.
// - Range depends on bytes per sample and on output port.
// - Maximum is memory bytes over bytes per sample.
// - Installed memory size is readable in megabytes.
// - Append enable adds one status byte after each block.
// - Status byte bit 0 is overload, bit 1 is ADC error.
// - On VME the status byte sits in low 8 bits of a word.
// - On local bus the status byte is flagged as the last byte.
// - Port selects VME word reads or byte stream, MSB first.
// - VME delivers 32-bit components upper half then lower half.
// - Continuous stream rate is paced to half the peak rate.
module sample_block_output_formatter
    import fmt_pkg::*;
#(
    parameter int MEM_MB = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire sample_t smp_in,
    input wire logic smp_valid,
    output logic smp_ready,
    input wire logic trig_in,
    output lbus_byte_t lbus_out,
    input wire logic lbus_accept
);
    localparam int MAXB = MEM_MB * 1048576;

    // Size arithmetic only holds for a power of two up to 512
    if (MEM_MB < 1 || MEM_MB > 512 ||
        (MEM_MB & (MEM_MB - 1)) != 0) begin : g_bad_mem
        $error("MEM_MB must be a power of two from 1 to 512");
    end

    // Next power of two at or above n
    function automatic logic [31:0] ceil_pow2(input logic [31:0] n);
        logic [31:0] p;
        p = 32'h0000_0001;
        for (int i = 0; i < 31; i++) begin
            if (p < n)
                p = p << 1;
        end
        return p;
    endfunction : ceil_pow2

    // Bytes per sample: 2, 4 or 8
    function automatic logic [3:0] bytes_per(input fmt_ctrl_t c);
        return 4'(2 << (32'(c.cplx) + 32'(c.wide)));
    endfunction : bytes_per

    // Minimum block size per port and bytes per sample
    function automatic logic [31:0] min_size(input fmt_ctrl_t c);
        logic [31:0] m;
        case (bytes_per(c))
            4'h2: m = c.lbus ? 32'h0000_0006 : 32'h0000_0003;
            4'h4: m = c.lbus ? 32'h0000_0003 : 32'h0000_0002;
            default: m = c.lbus ? 32'h0000_0002 : 32'h0000_0001;
        endcase
        return m;
    endfunction : min_size

    fmt_ctrl_t ctrl_ff, nxt_ctrl;
    logic [31:0] req_ff, nxt_req;
    logic [31:0] eff_ff, nxt_eff;
    logic err_ff, nxt_err;
    fmt_state_t st_ff, nxt_st;
    logic [31:0] cnt_ff, nxt_cnt;
    logic ovl_ff, nxt_ovl, aerr_ff, nxt_aerr;
    sample_t hold_ff, nxt_hold;
    logic [2:0] pos_ff, nxt_pos;
    logic busy_ff, nxt_busy;
    logic lastsmp_ff, nxt_lastsmp;
    logic [15:0] vword_ff, nxt_vword;
    logic vavail_ff, nxt_vavail;
    logic [7:0] stat_ff, nxt_stat;
    logic pace_ff, nxt_pace;
    logic smp_ready_ff, nxt_smp_ready;
    lbus_byte_t lb_ff, nxt_lb;
    logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd;
    logic arr_ff, nxt_arr, rv_ff, nxt_rv;
    logic [31:0] rd_ff, nxt_rd;
    logic [1:0] rr_ff, nxt_rr, br_ff, nxt_br;

    logic [31:0] want, lo, hi, sel;
    logic do_wr, cfg_wr, arm_cmd, trig_cmd, abort_cmd, vme_pop;
    logic emit, lbus_sel, last_unit;
    logic [3:0] units;
    logic [31:0] comp;
    logic [15:0] unit_word;
    logic [7:0] unit_byte;

    // Block size resolution, rerun on every setting change
    always_comb begin
        lo = min_size(nxt_ctrl);
        hi = 32'(MAXB) / 32'(bytes_per(nxt_ctrl));
        want = ceil_pow2(nxt_req);
        sel = want;
        if (want < lo)
            sel = ceil_pow2(lo);
        if (want > hi)
            sel = hi;
    end

    // Register writes
    always_comb begin
        nxt_awr = awr_ff;
        nxt_wr = wr_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        if (s_axil_awvalid && !awr_ff && !bv_ff) begin
            nxt_awr = 1'b1;
            nxt_awa = s_axil_awaddr;
        end
        if (s_axil_wvalid && !wr_ff && !bv_ff) begin
            nxt_wr = 1'b1;
            nxt_wd = s_axil_wdata;
        end
        do_wr = awr_ff && wr_ff && !bv_ff;
        if (do_wr) begin
            nxt_awr = 1'b0;
            nxt_wr = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = (awa_ff == `REG_CTRL || awa_ff == `REG_REQSIZE ||
                awa_ff == `REG_CMD) ? 2'h0 : 2'h2;
        end else if (bv_ff && s_axil_bready) begin
            nxt_bv = 1'b0;
        end
        cfg_wr = do_wr && (awa_ff == `REG_CTRL || awa_ff == `REG_REQSIZE);
        arm_cmd = do_wr && awa_ff == `REG_CMD && wd_ff[`CMD_ARM];
        trig_cmd = (do_wr && awa_ff == `REG_CMD && wd_ff[`CMD_TRIG]) ||
            trig_in;
        abort_cmd = cfg_wr ||
            (do_wr && awa_ff == `REG_CMD && wd_ff[`CMD_ABORT]);
        nxt_ctrl = ctrl_ff;
        nxt_req = req_ff;
        if (do_wr && awa_ff == `REG_CTRL)
            nxt_ctrl = fmt_ctrl_t'(wd_ff[4:0]);
        if (do_wr && awa_ff == `REG_REQSIZE) begin
            nxt_req = wd_ff;
            if (wd_ff == 32'h0)
                nxt_req = 32'h1;
            if (wd_ff > 32'(MAXB / 2))
                nxt_req = 32'(MAXB / 2);
        end
        nxt_eff = cfg_wr ? sel : eff_ff;
        nxt_err = cfg_wr ? (want != sel || (awa_ff == `REG_REQSIZE &&
            (wd_ff == 32'h0 || wd_ff > 32'(MAXB / 2)))) : err_ff;
    end

    // Register reads; a data register read pops one VME word
    always_comb begin
        nxt_arr = 1'b0;
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        vme_pop = 1'b0;
        if (rv_ff && s_axil_rready)
            nxt_rv = 1'b0;
        if (s_axil_arvalid && !arr_ff && !rv_ff) begin
            nxt_arr = 1'b1;
            nxt_rv = 1'b1;
            nxt_rr = 2'h0;
            case (s_axil_araddr)
                `REG_CTRL: nxt_rd = {27'h0, ctrl_ff};
                `REG_REQSIZE: nxt_rd = req_ff;
                `REG_EFFSIZE: nxt_rd = eff_ff;
                `REG_STATUS: nxt_rd = {25'h0, err_ff, 3'h0, vavail_ff,
                    vavail_ff, st_ff != ST_IDLE && st_ff != ST_DONE};
                `REG_MEMSIZE: nxt_rd = {16'h0, 16'(MEM_MB)};
                `REG_VME_DATA: begin
                    nxt_rd = {16'h0, vword_ff};
                    vme_pop = vavail_ff;
                end
                default: begin
                    nxt_rd = 32'h0;
                    nxt_rr = 2'h2;
                end
            endcase
        end
    end

    // Formatter: sample capture, word/byte sequencing, block control
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_ovl = ovl_ff;
        nxt_aerr = aerr_ff;
        nxt_hold = hold_ff;
        nxt_pos = pos_ff;
        nxt_busy = busy_ff;
        nxt_lastsmp = lastsmp_ff;
        nxt_vword = vword_ff;
        nxt_vavail = vavail_ff && !vme_pop;
        nxt_stat = stat_ff;
        nxt_pace = pace_ff;
        nxt_lb = lb_ff;
        lbus_sel = ctrl_ff.lbus;
        if (lb_ff.valid && lbus_accept) begin
            nxt_lb.valid = 1'b0;
            nxt_lb.last = 1'b0;
        end
        units = ctrl_ff.wide ? 4'h2 : 4'h1;
        if (lbus_sel)
            units = units << 1;
        if (ctrl_ff.cplx)
            units = units << 1;
        comp = (ctrl_ff.cplx && (pos_ff >= 3'(units >> 1))) ?
            hold_ff.imag_component_word :
            hold_ff.real_component_word;
        unit_word = ctrl_ff.wide && !pos_ff[0] ? comp[31:16] :
            comp[15:0];
        case (ctrl_ff.wide ? pos_ff[1:0] : {1'b1, pos_ff[0]})
            2'h0: unit_byte = comp[31:24];
            2'h1: unit_byte = comp[23:16];
            2'h2: unit_byte = comp[15:8];
            default: unit_byte = comp[7:0];
        endcase
        last_unit = pos_ff == 3'(units - 4'h1);
        emit = busy_ff && (lbus_sel ? (!lb_ff.valid || lbus_accept) :
            (!vavail_ff || vme_pop));
        nxt_pace = ctrl_ff.cont ? !pace_ff : 1'b1;
        nxt_smp_ready = st_ff == ST_RUN && !nxt_busy && pace_ff;
        if (emit) begin
            if (lbus_sel) begin
                nxt_lb = '{data: unit_byte, last: 1'b0, valid: 1'b1};
                if (last_unit && lastsmp_ff && !ctrl_ff.append)
                    nxt_lb.last = 1'b1;
            end else begin
                nxt_vword = unit_word;
                nxt_vavail = 1'b1;
            end
            nxt_pos = pos_ff + 3'h1;
            if (last_unit) begin
                nxt_busy = 1'b0;
                nxt_pos = 3'h0;
            end
        end
        case (st_ff)
            ST_IDLE: if (arm_cmd) nxt_st = ST_ARMED;
            ST_ARMED: if (trig_cmd) begin
                nxt_st = ST_RUN;
                nxt_cnt = 32'h0;
                nxt_ovl = 1'b0;
                nxt_aerr = 1'b0;
            end
            ST_RUN: begin
                if (smp_valid && smp_ready_ff) begin
                    nxt_hold = smp_in;
                    nxt_busy = 1'b1;
                    nxt_pos = 3'h0;
                    nxt_ovl = ovl_ff | smp_in.overload;
                    nxt_aerr = aerr_ff | smp_in.adc_error;
                    nxt_cnt = cnt_ff + 32'h1;
                    nxt_lastsmp = cnt_ff + 32'h1 == eff_ff;
                    nxt_smp_ready = 1'b0;
                end
                if (busy_ff && emit && last_unit && lastsmp_ff) begin
                    nxt_stat = {6'h0, aerr_ff, ovl_ff};
                    nxt_lastsmp = 1'b0;
                    nxt_st = ctrl_ff.append ? ST_STAT : ST_DONE;
                    nxt_smp_ready = 1'b0;
                end
            end
            ST_STAT: if (!busy_ff && (lbus_sel ? (!lb_ff.valid ||
                    lbus_accept) : (!vavail_ff || vme_pop))) begin
                if (lbus_sel)
                    nxt_lb = '{data: stat_ff, last: 1'b1,
                        valid: 1'b1};
                else begin
                    nxt_vword = {8'h00, stat_ff};
                    nxt_vavail = 1'b1;
                end
                nxt_st = ST_DONE;
            end
            ST_DONE: begin
                // Continuous mode rolls into the next block at once
                if (ctrl_ff.cont) begin
                    nxt_st = ST_RUN;
                    nxt_cnt = 32'h0;
                    nxt_ovl = 1'b0;
                    nxt_aerr = 1'b0;
                end else begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
        if (abort_cmd) begin
            nxt_st = ST_IDLE;
            nxt_busy = 1'b0;
            nxt_pos = 3'h0;
            nxt_smp_ready = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_ff <= fmt_ctrl_t'(`CTRL_RESET);
            req_ff <= `REQSIZE_RESET;
            eff_ff <= `REQSIZE_RESET;
            err_ff <= 1'b0;
            st_ff <= ST_IDLE;
            cnt_ff <= 32'h0;
            ovl_ff <= 1'b0;
            aerr_ff <= 1'b0;
            hold_ff <= '0;
            pos_ff <= 3'h0;
            busy_ff <= 1'b0;
            lastsmp_ff <= 1'b0;
            vword_ff <= 16'h0;
            vavail_ff <= 1'b0;
            stat_ff <= 8'h0;
            pace_ff <= 1'b1;
            smp_ready_ff <= 1'b0;
            lb_ff <= '0;
            awr_ff <= 1'b0;
            wr_ff <= 1'b0;
            awa_ff <= 8'h0;
            wd_ff <= 32'h0;
            bv_ff <= 1'b0;
            br_ff <= 2'h0;
            arr_ff <= 1'b0;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0;
            rr_ff <= 2'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            req_ff <= nxt_req;
            eff_ff <= nxt_eff;
            err_ff <= nxt_err;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ovl_ff <= nxt_ovl;
            aerr_ff <= nxt_aerr;
            hold_ff <= nxt_hold;
            pos_ff <= nxt_pos;
            busy_ff <= nxt_busy;
            lastsmp_ff <= nxt_lastsmp;
            vword_ff <= nxt_vword;
            vavail_ff <= nxt_vavail;
            stat_ff <= nxt_stat;
            pace_ff <= nxt_pace;
            smp_ready_ff <= nxt_smp_ready;
            lb_ff <= nxt_lb;
            awr_ff <= nxt_awr;
            wr_ff <= nxt_wr;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            arr_ff <= nxt_arr;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
        end
    end

    assign s_axil_awready = awr_ff;
    assign s_axil_wready = wr_ff;
    assign s_axil_bvalid = bv_ff;
    assign s_axil_bresp = br_ff;
    assign s_axil_arready = arr_ff;
    assign s_axil_rvalid = rv_ff;
    assign s_axil_rdata = rd_ff;
    assign s_axil_rresp = rr_ff;
    assign smp_ready = smp_ready_ff;
    assign lbus_out = lb_ff;
endmodule : sample_block_output_formatter

/* bench/fmt_checker.sv */
// Purpose: Port checks for the output formatter
// Assumes: Bound to the top module; sync active-high reset
// Notes: Bus answers, holding and stream flags
`timescale 1ns/10ps
module fmt_checker
    import fmt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_bvalid,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic smp_ready,
    input wire lbus_byte_t lbus_out,
    input wire logic lbus_accept
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    quiet_rst_a: assert property (disable iff (1'h0) sys_rst |=>
        !s_axil_rvalid && !s_axil_bvalid && !lbus_out.valid && !smp_ready)
        else $error("output active after reset");
    rd_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read answer dropped");
    wr_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=>
        s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write answer dropped");
    byte_hold_a: assert property (
        lbus_out.valid && !lbus_accept |=> $stable(lbus_out))
        else $error("stream byte changed while stalled");
    rd_answer_a: assert property (s_axil_arvalid && !s_axil_arready &&
        !s_axil_rvalid |=> s_axil_arready && s_axil_rvalid)
        else $error("read not answered next cycle");
    bad_addr_a: assert property (s_axil_arvalid && !s_axil_arready &&
        !s_axil_rvalid && s_axil_araddr > 8'h18 |=>
        s_axil_rresp == 2'h2 && s_axil_rdata == 32'h0)
        else $error("unmapped read not refused");
    wr_answer_a: assert property (s_axil_awvalid && s_axil_wvalid &&
        !s_axil_awready && !s_axil_bvalid |-> ##[1:3] s_axil_bvalid)
        else $error("write not answered");
    aw_cause_a: assert property ($rose(s_axil_awready) |->
        $past(s_axil_awvalid))
        else $error("address taken without request");
    last_flag_a: assert property (
        lbus_out.last |-> lbus_out.valid)
        else $error("last flag on idle stream");
endmodule : fmt_checker
bind sample_block_output_formatter fmt_checker u_chk (.*);

/* bench/lbus_sink.sv */
// Purpose: Neighbour module that consumes the byte stream
// Assumes: A byte moves on an edge with valid and accept high
// Notes: Slow mode stalls at random
`timescale 1ns/10ps
module lbus_sink (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    output logic lbus_accept
);
    int seed = 52;
    always @(posedge clock) begin
        lbus_accept <= !sys_rst && (!slow || $random(seed) % 3 == 0);
    end
endmodule : lbus_sink

/* bench/sample_block_output_formatter_bench.sv */
// Purpose: Self-checking bench for the output formatter
// Assumes: Register map from fmt_cfg.svh; 25 MHz clock
// Notes: Drivers queue expected units; a monitor compares them
`timescale 1ns/10ps
`include "fmt_cfg.svh"
module sample_block_output_formatter_bench
    import fmt_pkg::*;
;
    logic clock = '0;
    logic sys_rst = '1;
    logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0;
    logic s_axil_awvalid = '0, s_axil_wvalid = '0, s_axil_bready = '0;
    logic s_axil_arvalid = '0, s_axil_rready = '0, smp_valid = '0;
    logic trig_in = '0, slow = '0;
    logic [31:0] s_axil_wdata = '0, s_axil_rdata, rv;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
    logic s_axil_rvalid, smp_ready, lbus_accept;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    sample_t smp_in = '0;
    lbus_byte_t lbus_out;
    int n_fail = 0, cmp_count = 0, seed = 52;
    logic [67:0] rq[$], e;
    logic [16:0] lq[$], f;
    logic [31:0] vq[$];
    logic cplx, wide, lbus, apnd;
    logic [4:0] tc[7] = '{5'h02, 5'h02, 5'h02, 5'h00, 5'h13, 5'h10, 5'h00};
    int tr[7] = '{5, 0, 32'h400000, -1, 1, 3, 3};
    int te[7] = '{8, 2, 32'h200000, 32'h400000, 2, 8, 4};
    logic [6:0] tx = 7'h36;

    always #20 clock = ~clock;
    sample_block_output_formatter #(.MEM_MB(8)) dut (.*);
    lbus_sink sink (.clock(clock), .sys_rst(sys_rst), .slow(slow),
        .lbus_accept(lbus_accept));

    task automatic summarize;
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic tmo;
        n_fail++;
        summarize();
    endtask : tmo

    task automatic chk(string nm, logic [33:0] x, logic [33:0] g,
        logic [33:0] m);
        cmp_count++;
        if ((g & m) !== (x & m)) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, x & m, g & m);
        end
    endtask : chk

    // Values are stable at the falling edge and move at the next rise
    always @(negedge clock) begin
        if (s_axil_rvalid && s_axil_rready) begin
            e = rq.size() ? rq.pop_front() : '1;
            chk("rdata", e[33:0], {s_axil_rresp, s_axil_rdata}, e[67:34]);
        end
        if (s_axil_bvalid && s_axil_bready) begin
            e = rq.size() ? rq.pop_front() : '1;
            chk("bresp", e[33:0], {s_axil_bresp, 32'h0}, e[67:34]);
        end
        if (lbus_out.valid && lbus_accept) begin
            f = lq.size() ? lq.pop_front() : '1;
            chk("lbus", {25'h0, f[8:0]}, {25'h0, lbus_out.last,
                lbus_out.data}, {25'h0, 1'h1, f[16:9]});
        end
    end

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 0);
        int n = 0;
        logic ha, hw, hb;
        rq.push_back({34'h3_0000_0000, r, 32'h0});
        @(posedge clock);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= '1;
        s_axil_wvalid <= '1;
        s_axil_bready <= '1;
        do begin
            @(negedge clock);
            ha = s_axil_awready;
            hw = s_axil_wready;
            hb = s_axil_bvalid;
            @(posedge clock);
            if (ha) s_axil_awvalid <= '0;
            if (hw) s_axil_wvalid <= '0;
            n++;
        end while (!hb && n < 50);
        s_axil_bready <= '0;
        if (!hb) tmo();
    endtask : wr

    task automatic rd(logic [7:0] a, logic [33:0] m, logic [33:0] x);
        int n = 0;
        logic hr, hv;
        rq.push_back({m, x});
        @(posedge clock);
        s_axil_araddr <= a;
        s_axil_arvalid <= '1;
        s_axil_rready <= '1;
        do begin
            @(negedge clock);
            hr = s_axil_arready;
            hv = s_axil_rvalid;
            rv = s_axil_rdata;
            @(posedge clock);
            if (hr) s_axil_arvalid <= '0;
            n++;
        end while (!hv && n < 50);
        s_axil_rready <= '0;
        if (!hv) tmo();
    endtask : rd

    task automatic feed(int ns, int eff, logic [1:0] fl);
        logic [31:0] re, im, w;
        logic ov, er, so, se, h;
        int n;
        so = 0;
        se = 0;
        @(posedge clock);
        for (int s = 0; s < ns; s++) begin
            re = $random(seed);
            im = $random(seed);
            if (!wide) begin
                re = {2{re[15:0]}};
                im = {2{im[15:0]}};
            end
            ov = fl[0] && s == 0;
            er = fl[1] && s == ns - 1;
            for (int c = 0; c <= cplx; c++) begin
                w = c ? im : re;
                for (int b = wide ? 3 : 1; b >= 0; b--) begin
                    if (lbus)
                        lq.push_back({8'hFF, !apnd && (s + 1) % eff == 0
                            && c == cplx && b == 0, w[8 * b +: 8]});
                    else if (b % 2 == 0)
                        vq.push_back({16'hFFFF, w[8 * b +: 16]});
                end
            end
            smp_in <= {re, im, ov, er};
            smp_valid <= '1;
            n = 0;
            do begin
                @(negedge clock);
                h = smp_ready;
                n++;
                @(posedge clock);
            end while (!h && n < 400);
            if (!h) tmo();
            so |= ov;
            se |= er;
            if ((s + 1) % eff == 0) begin
                if (apnd && lbus) lq.push_back({8'h03, 1'h1, 6'h0, se, so});
                if (apnd && !lbus) vq.push_back({16'hFF03, 14'h0, se, so});
                so = 0;
                se = 0;
            end
        end
        smp_valid <= '0;
    endtask : feed

    task automatic drain(int nw);
        logic [31:0] v;
        int n;
        for (int k = 0; k < nw; k++) begin
            n = 0;
            do begin
                rd(`REG_STATUS, 34'h0, 34'h0);
                n++;
            end while (!rv[`STAT_AVAIL] && n < 200);
            if (!rv[`STAT_AVAIL]) tmo();
            v = vq.size() ? vq.pop_front() : '1;
            rd(`REG_VME_DATA, {18'h0, v[31:16]}, {18'h0, v[15:0]});
        end
    endtask : drain

    task automatic run(logic [4:0] ct, int rqs, int eff, int ns, int nw,
        logic pin, logic [1:0] fl);
        int n = 0;
        {lbus, apnd, wide, cplx} = {ct[4:3], ct[1:0]};
        slow <= !pin;
        wr(`REG_CTRL, {27'h0, ct});
        wr(`REG_REQSIZE, rqs);
        rd(`REG_EFFSIZE, '1, {2'h0, eff});
        wr(`REG_CMD, 32'h1);
        if (pin) begin
            @(posedge clock);
            trig_in <= '1;
            @(posedge clock);
            trig_in <= '0;
        end else
            wr(`REG_CMD, 32'h2);
        fork
            feed(ns, eff, fl);
            drain(nw);
        join
        while (lq.size() && n < 900) begin
            @(posedge clock);
            n++;
        end
        if (lq.size()) tmo();
    endtask : run

    initial begin
        repeat (90000) @(posedge clock);
        tmo();
    end

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= '0;
        rd(`REG_CTRL, '1, {2'h0, `CTRL_RESET});
        rd(`REG_REQSIZE, '1, {2'h0, `REQSIZE_RESET});
        rd(`REG_EFFSIZE, '1, 34'h400);
        rd(`REG_MEMSIZE, '1, {18'h0, `STD_MEM_MB});
        rd(8'h1C, '1, 34'h2_0000_0000);
        wr(`REG_EFFSIZE, 32'h5, 2'h2);
        foreach (tc[i]) begin
            wr(`REG_CTRL, {27'h0, tc[i]});
            if (tr[i] >= 0) wr(`REG_REQSIZE, tr[i]);
            rd(`REG_EFFSIZE, '1, {2'h0, te[i]});
            rd(`REG_STATUS, 34'h40, {27'h0, tx[i], 6'h0});
        end
        run(5'h1B, 2, 2, 2, 0, 1, 2'h1);
        @(posedge clock);
        smp_valid <= '1;
        repeat (16) begin
            @(negedge clock);
            chk("smp_ready", 34'h0, {33'h0, smp_ready}, 34'h1);
        end
        @(posedge clock);
        smp_valid <= '0;
        run(5'h1B, 2, 2, 2, 0, 0, 2'h2);
        run(5'h11, 4, 4, 4, 0, 1, 2'h0);
        run(5'h0B, 1, 1, 1, 5, 0, 2'h3);
        run(5'h08, 3, 4, 4, 5, 1, 2'h1);
        run(5'h06, 2, 2, 4, 8, 0, 2'h0);
        wr(`REG_CMD, 32'h4);
        summarize();
    end
endmodule : sample_block_output_formatter_bench
